// file: design/asp_regs.svh
// constants of the adc serial port: addresses, field positions, reset values, frame counts
// assumes a 40 MHz system clock and a host that clocks the port with sclk
// Notes on behaviour
// - default sync pulse restarts sequence at first channel
// - alternate sync never resets the channel sequencer
// - alternate sync: new channel waits for sync high
// - sync low resets core, forces ready high
// - chip select active low; deselected port ignored
// - chip select tied low keeps output driven
// - output changes on falling, host samples rising
// - continuous or burst serial clock both work
// - ready goes low when result completes
// - unread ready returns high before next update
// - ready optionally mirrored on auxiliary pin
// - streaming mode makes own clock and frame
// - streaming mode owns data output until disabled
// - write moves data word to addressed register
// - any register can be loaded for readout
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

`define ASP_WORD_W 24
`define ASP_FIFO_DEPTH 32

`define ASP_ADDR_CTRL 4'h0
`define ASP_ADDR_CHAN_EN 4'h1
`define ASP_ADDR_DATA 4'h2
`define ASP_ADDR_STATUS 4'h3

`define ASP_CTRL_ALTERNATE_SYNC_MODE 0
`define ASP_CTRL_CONT_TX 1
`define ASP_CTRL_AUX_RDY 2
`define ASP_CTRL_RST 3'h0
`define ASP_CHAN_EN_RST 4'h1

`define ASP_INSTR_RD_BIT 7
`define ASP_CNT_INSTR_LAST 6'h07
`define ASP_CNT_DATA_FIRST 6'h10
`define ASP_CNT_FRAME_LAST 6'h27
`define ASP_CNT_FRAME_END 6'h28

`define ASP_CLK_PERIOD_NS 25
`define ASP_STREAM_PERIOD_NS 100
`define ASP_STREAM_HALF_CYC ((`ASP_STREAM_PERIOD_NS / 2) / `ASP_CLK_PERIOD_NS)

`endif

// file: design/asp_pkg.sv
// types of the adc serial port
// assumes asp_regs.svh for the numeric constants
package asp_pkg;

	typedef enum logic [1:0] {
		SEQ_HOLD = 2'b00,
		SEQ_RUN = 2'b01,
		SEQ_WAIT = 2'b10
	} asp_seq_state_t;

	typedef enum logic {
		STR_IDLE = 1'b0,
		STR_SHIFT = 1'b1
	} asp_str_state_t;

endpackage

// file: design/asp_stream_if.sv
// valid/ready word carrier between the port and its result fifo
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface asp_stream_if #(
	parameter int W = 24
) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: design/asp_fifo.sv
// result fifo of flip-flops with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// fill side
	asp_stream_if.snk in_if,
	// drain side
	asp_stream_if.src out_if
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	wire push = in_if.valid & in_if.ready;
	wire pop = out_if.valid & out_if.ready;

	assign in_if.ready = (count_reg != (AW+1)'(DEPTH));
	assign out_if.valid = (count_reg != '0);
	assign out_if.data = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_if.data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // asp_fifo
`default_nettype wire

// file: design/asp_top.sv
// serial host port, sync sequencer and result streamer of a multichannel adc
// assumes the host masters sclk (link domain) and a 40 MHz system clock runs the rest
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
module asp_top
	import asp_pkg::*;
(
	// system clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// serial port pins
	input wire logic sclk_i,
	input wire logic cs_b_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// sync, auxiliary and streaming pins
	input wire logic sync_b_i,
	output logic aux_digital_pin_one_o,
	output logic stream_data_clock_o,
	output logic stream_frame_o,
	// converter core
	input wire logic result_valid_i,
	input wire logic [`ASP_WORD_W-1:0] result_data_i,
	output logic result_ready_o,
	output logic [1:0] channel_o,
	output logic sample_enable_o,
	output logic core_reset_o
);

	// nearest enabled channel after ch, ch itself last; unchanged if none enabled
	function automatic logic [1:0] next_chan(input logic [1:0] ch, input logic [3:0] en);
		logic [1:0] c;
		logic [1:0] r;
		r = ch;
		for (int i = 4; i >= 1; i--) begin
			c = ch + 2'(i);
			if (en[c]) begin
				r = c;
			end
		end
		return r;
	endfunction

	// link domain: frame logic cleared whenever chip select is high
	wire frame_rst_b = rst_b_i & ~cs_b_i;
	logic [5:0] cnt_reg;
	logic [`ASP_WORD_W-1:0] in_shift_reg;
	logic [7:0] instr_reg;
	logic [`ASP_WORD_W-1:0] wdata_reg;
	logic req_tgl_reg;
	logic [`ASP_WORD_W-1:0] out_shift_reg;
	logic data_phase_reg;
	wire [7:0] instr_now = {in_shift_reg[6:0], sdi_i};
	wire instr_is_rd = instr_now[`ASP_INSTR_RD_BIT];

	// counts only edges seen inside a frame, so burst or free-running sclk both work
	always_ff @(posedge sclk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			cnt_reg <= '0;
			in_shift_reg <= '0;
		end else begin
			in_shift_reg <= {in_shift_reg[`ASP_WORD_W-2:0], sdi_i};
			if (cnt_reg != `ASP_CNT_FRAME_END) begin
				cnt_reg <= cnt_reg + 6'h01;
			end
		end
	end

	// request words held until the next frame overwrites them; not cleared by chip select
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			instr_reg <= '0;
			wdata_reg <= '0;
			req_tgl_reg <= 1'b0;
		end else if (!cs_b_i) begin
			if (cnt_reg == `ASP_CNT_INSTR_LAST) begin
				instr_reg <= instr_now;
				if (instr_is_rd) begin
					req_tgl_reg <= ~req_tgl_reg;
				end
			end else if (cnt_reg == `ASP_CNT_FRAME_LAST && !instr_reg[`ASP_INSTR_RD_BIT]) begin
				wdata_reg <= {in_shift_reg[`ASP_WORD_W-2:0], sdi_i};
				req_tgl_reg <= ~req_tgl_reg;
			end
		end
	end

	// read word is sampled eight and a half sclk periods after the request toggle
	logic [`ASP_WORD_W-1:0] rd_data_reg;
	always_ff @(negedge sclk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			out_shift_reg <= '0;
			data_phase_reg <= 1'b0;
		end else if (cnt_reg == `ASP_CNT_DATA_FIRST) begin
			out_shift_reg <= instr_reg[`ASP_INSTR_RD_BIT] ? rd_data_reg : '0;
			data_phase_reg <= 1'b1;
		end else begin
			out_shift_reg <= {out_shift_reg[`ASP_WORD_W-2:0], 1'b0};
		end
	end

	// system domain: synchronisers
	logic [1:0] sync_pin_reg;
	logic [1:0] req_sync_reg;
	logic req_prev_reg;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_pin_reg <= 2'h3;
			req_sync_reg <= 2'h0;
			req_prev_reg <= 1'b0;
		end else begin
			sync_pin_reg <= {sync_pin_reg[0], sync_b_i};
			req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
			req_prev_reg <= req_sync_reg[1];
		end
	end
	wire sync_low = ~sync_pin_reg[1];
	wire req_event = req_sync_reg[1] ^ req_prev_reg;
	wire [3:0] req_addr = instr_reg[3:0];
	wire req_rd = req_event & instr_reg[`ASP_INSTR_RD_BIT];
	wire req_wr = req_event & ~instr_reg[`ASP_INSTR_RD_BIT];

	// control registers
	logic [2:0] ctrl_reg;
	logic [3:0] chan_en_reg;
	wire alternate_sync_mode = ctrl_reg[`ASP_CTRL_ALTERNATE_SYNC_MODE];
	wire cont_tx = ctrl_reg[`ASP_CTRL_CONT_TX];
	wire aux_rdy = ctrl_reg[`ASP_CTRL_AUX_RDY];
	wire multi_chan = |(chan_en_reg & (chan_en_reg - 4'h1));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= `ASP_CTRL_RST;
			chan_en_reg <= `ASP_CHAN_EN_RST;
		end else if (req_wr && req_addr == `ASP_ADDR_CTRL) begin
			ctrl_reg <= wdata_reg[2:0];
		end else if (req_wr && req_addr == `ASP_ADDR_CHAN_EN) begin
			chan_en_reg <= wdata_reg[3:0];
		end
	end

	// result staging and fifo
	asp_stream_if #(.W(`ASP_WORD_W)) fill_if ();
	asp_stream_if #(.W(`ASP_WORD_W)) drain_if ();
	asp_fifo #(
		.WIDTH(`ASP_WORD_W),
		.DEPTH(`ASP_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_if(fill_if),
		.out_if(drain_if)
	);

	logic stage_valid_reg;
	logic [`ASP_WORD_W-1:0] stage_data_reg;
	logic rdy_b_reg;
	asp_seq_state_t seq_state_reg;
	asp_seq_state_t seq_state_next;
	logic [1:0] chan_reg;
	logic [1:0] chan_next;

	// a full fifo holds the stage, which stalls the converter core
	assign result_ready_o = ~stage_valid_reg & (seq_state_reg != SEQ_HOLD);
	wire take = result_valid_i & result_ready_o;
	assign fill_if.valid = stage_valid_reg;
	assign fill_if.data = stage_data_reg;
	wire push = fill_if.valid & fill_if.ready;

	// streamer signals needed by the drain select
	asp_str_state_t str_state_reg;
	logic [3:0] div_reg;
	logic stream_clk_reg;
	logic [4:0] str_cnt_reg;
	logic [`ASP_WORD_W-1:0] str_shift_reg;
	logic frame_reg;
	wire div_zero = (div_reg == 4'h0);
	wire str_fall = cont_tx & div_zero & stream_clk_reg;
	wire str_free = (str_state_reg == STR_IDLE) | (str_cnt_reg == 5'h00);
	wire str_start = str_fall & str_free & drain_if.valid;
	wire host_pop = req_rd & (req_addr == `ASP_ADDR_DATA) & ~cont_tx;
	assign drain_if.ready = cont_tx ? str_start : host_pop;
	wire pop = drain_if.valid & drain_if.ready;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage_valid_reg <= 1'b0;
			stage_data_reg <= '0;
		end else begin
			if (take) begin
				stage_valid_reg <= 1'b1;
				stage_data_reg <= result_data_i;
			end else if (push) begin
				stage_valid_reg <= 1'b0;
			end
		end
	end

	// ready is high while idle or read; high for the staging cycle before each write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdy_b_reg <= 1'b1;
		end else if (sync_low) begin
			rdy_b_reg <= 1'b1;
		end else if (take) begin
			rdy_b_reg <= 1'b1;
		end else if (push) begin
			rdy_b_reg <= 1'b0;
		end else if (pop) begin
			rdy_b_reg <= 1'b1;
		end
	end

	// channel sequencer
	always_comb begin
		seq_state_next = seq_state_reg;
		chan_next = chan_reg;
		unique case (seq_state_reg)
			SEQ_HOLD: begin
				if (!alternate_sync_mode) begin
					chan_next = next_chan(2'h3, chan_en_reg);
				end
				if (!sync_low) begin
					seq_state_next = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (sync_low) begin
					seq_state_next = SEQ_HOLD;
				end else if (take) begin
					chan_next = next_chan(chan_reg, chan_en_reg);
					if (alternate_sync_mode && multi_chan) begin
						seq_state_next = SEQ_WAIT;
					end
				end
			end
			SEQ_WAIT: begin
				// sequencer keeps its channel; only a fresh sync pulse releases sampling
				if (sync_low) begin
					seq_state_next = SEQ_HOLD;
				end
			end
			default: begin
				seq_state_next = SEQ_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_state_reg <= SEQ_HOLD;
			chan_reg <= 2'h0;
		end else begin
			seq_state_reg <= seq_state_next;
			chan_reg <= chan_next;
		end
	end

	assign channel_o = chan_reg;
	assign sample_enable_o = (seq_state_reg == SEQ_RUN);
	assign core_reset_o = (seq_state_reg == SEQ_HOLD);

	// register readout
	wire [`ASP_WORD_W-1:0] status_word = {18'h0_0000, seq_state_reg, chan_reg, stage_valid_reg,
		rdy_b_reg};
	wire [`ASP_WORD_W-1:0] rd_mux =
		(req_addr == `ASP_ADDR_CTRL) ? {21'h00_0000, ctrl_reg} :
		(req_addr == `ASP_ADDR_CHAN_EN) ? {20'h0_0000, chan_en_reg} :
		(req_addr == `ASP_ADDR_DATA) ? (drain_if.valid ? drain_if.data : '0) :
		(req_addr == `ASP_ADDR_STATUS) ? status_word : '0;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_reg <= '0;
		end else if (req_rd) begin
			rd_data_reg <= rd_mux;
		end
	end

	// streamer: clock divided from clk_i, data moves on its falling edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_reg <= 4'h0;
			stream_clk_reg <= 1'b0;
		end else if (!cont_tx) begin
			div_reg <= 4'h0;
			stream_clk_reg <= 1'b0;
		end else if (div_zero) begin
			div_reg <= 4'(`ASP_STREAM_HALF_CYC - 1);
			stream_clk_reg <= ~stream_clk_reg;
		end else begin
			div_reg <= div_reg - 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			str_state_reg <= STR_IDLE;
			str_cnt_reg <= 5'h00;
			str_shift_reg <= '0;
			frame_reg <= 1'b0;
		end else if (!cont_tx) begin
			str_state_reg <= STR_IDLE;
			frame_reg <= 1'b0;
		end else if (str_start) begin
			str_state_reg <= STR_SHIFT;
			str_cnt_reg <= 5'(`ASP_WORD_W - 1);
			str_shift_reg <= drain_if.data;
			frame_reg <= 1'b1;
		end else if (str_fall) begin
			frame_reg <= 1'b0;
			if (str_free) begin
				str_state_reg <= STR_IDLE;
			end else begin
				str_cnt_reg <= str_cnt_reg - 5'h01;
				str_shift_reg <= {str_shift_reg[`ASP_WORD_W-2:0], 1'b0};
			end
		end
	end

	assign stream_data_clock_o = stream_clk_reg;
	assign stream_frame_o = frame_reg;

	// pins: chip select gates the driver directly, since no clock runs while deselected
	assign sdo_oe_o = cont_tx | ~cs_b_i;
	assign sdo_o = cont_tx ? (str_state_reg == STR_SHIFT) & str_shift_reg[`ASP_WORD_W-1] :
		data_phase_reg ? out_shift_reg[`ASP_WORD_W-1] : rdy_b_reg;
	assign aux_digital_pin_one_o = aux_rdy ? rdy_b_reg : 1'b1;

endmodule // asp_top
`default_nettype wire

// file: verif/asp_assertions.sv
// concurrent checks on the adc serial port pins, bound into asp_top
// assumes the system clock domain; link-side bit timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module asp_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// pins watched
	input wire logic cs_b_i,
	input wire logic sync_b_i,
	input wire logic sdo_oe_o,
	input wire logic aux_digital_pin_one_o,
	input wire logic stream_data_clock_o,
	input wire logic stream_frame_o,
	input wire logic result_valid_i,
	input wire logic result_ready_o,
	input wire logic [1:0] channel_o,
	input wire logic sample_enable_o,
	input wire logic core_reset_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	oe_when_sel_a: assert property (!cs_b_i |-> sdo_oe_o)
		else $error("sdo not driven while selected");
	sync_hold_a: assert property (!sync_b_i [*4] |-> core_reset_o)
		else $error("sync low did not hold the core");
	hold_quiet_a: assert property (core_reset_o |-> !sample_enable_o && !result_ready_o)
		else $error("core sampling while held");
	hold_ready_a: assert property (core_reset_o [*2] |-> aux_digital_pin_one_o)
		else $error("ready low while held");
	take_stage_a: assert property (result_valid_i && result_ready_o |=>
		!result_ready_o && aux_digital_pin_one_o)
		else $error("ready not raised before update");
	hold_chan_a: assert property (core_reset_o [*3] |-> $stable(channel_o))
		else $error("channel moved during hold");
	stream_oe_a: assert property (stream_data_clock_o || stream_frame_o |-> sdo_oe_o)
		else $error("sdo released while streaming");
	stream_rate_a: assert property ($rose(stream_data_clock_o) |=>
		stream_data_clock_o ##1 !stream_data_clock_o)
		else $error("stream clock half period wrong");
	frame_len_a: assert property ($rose(stream_frame_o) |->
		stream_frame_o [*4] ##1 !stream_frame_o)
		else $error("frame not one bit period");
	run_excl_a: assert property (sample_enable_o |-> !core_reset_o)
		else $error("sampling and hold together");
	run_after_sync_a: assert property ($rose(sample_enable_o) |-> $past(sync_b_i, 3))
		else $error("sampling started without sync high");
endmodule // asp_checker
bind asp_top asp_checker u_asp_checker (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.cs_b_i(cs_b_i),
	.sync_b_i(sync_b_i),
	.sdo_oe_o(sdo_oe_o),
	.aux_digital_pin_one_o(aux_digital_pin_one_o),
	.stream_data_clock_o(stream_data_clock_o),
	.stream_frame_o(stream_frame_o),
	.result_valid_i(result_valid_i),
	.result_ready_o(result_ready_o),
	.channel_o(channel_o),
	.sample_enable_o(sample_enable_o),
	.core_reset_o(core_reset_o)
);
`default_nettype wire

// file: verif/asp_host_model.sv
// host model: serial master with 80 ns sclk and stream receiver
// assumes the bench calls its tasks one at a time; sclk stands low between frames
`timescale 1ns/1ps
`default_nettype none
module asp_host (
	// serial pins
	output logic sclk_o,
	output logic cs_b_o,
	output logic sdi_o,
	input wire logic sdo_i,
	// stream pins
	input wire logic sclk_s_i,
	input wire logic frame_i
);
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		sdi_o = 1'b0;
	end
	// gap stalls sclk mid-word, modelling a gated burst clock
	task automatic xfer(input logic [7:0] ins, input logic [23:0] wd, input int gap,
		output logic [23:0] rd);
		logic [39:0] sh;
		sh = {ins, 8'h00, wd};
		cs_b_o = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			sdi_o = sh[i];
			#40 sclk_o = 1'b1;
			if (i < 24) rd[i] = sdo_i;
			#40 sclk_o = 1'b0;
			if (i == 20) #(gap);
		end
		sdi_o = ~sdi_o;
		#40 cs_b_o = 1'b1;
		#80;
	endtask
	// receiver clocked by the device's own stream clock
	task automatic recv(output logic [23:0] w);
		do @(posedge sclk_s_i); while (frame_i !== 1'b1);
		w[23] = sdo_i;
		for (int i = 22; i >= 0; i--) begin
			@(posedge sclk_s_i);
			w[i] = sdo_i;
		end
	endtask
endmodule // asp_host
`default_nettype wire

// file: verif/test_adc_serial_port_and_sync.sv
// self-checking bench for asp_top with host model
// assumes asp_host drives the serial pins; bench drives sync and core result
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
module test_adc_serial_port_and_sync;
	logic clk_i, rst_b_i, sclk_i, cs_b_i, sdi_i, sdo_o, sdo_oe_o, sync_b_i, aux;
	logic sclk_s, frame, result_valid_i, result_ready_o, sample_enable_o, core_reset_o;
	logic [23:0] result_data_i;
	logic [1:0] channel_o;
	int fail_count = 0;
	int checks_done = 0;

	asp_top u_asp_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i),
		.sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sync_b_i(sync_b_i),
		.aux_digital_pin_one_o(aux), .stream_data_clock_o(sclk_s), .stream_frame_o(frame),
		.result_valid_i(result_valid_i), .result_data_i(result_data_i),
		.result_ready_o(result_ready_o), .channel_o(channel_o),
		.sample_enable_o(sample_enable_o), .core_reset_o(core_reset_o));
	// a released sdo shows the inverse, so a stale bit cannot pass as data
	wire sdo_seen = sdo_oe_o ? sdo_o : ~sdo_o;
	asp_host u_asp_host (.sclk_o(sclk_i), .cs_b_o(cs_b_i), .sdi_o(sdi_i), .sdo_i(sdo_seen),
		.sclk_s_i(sclk_s), .frame_i(frame));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		logic [23:0] x;
		u_asp_host.xfer({4'h0, a}, d, 0, x);
		cyc(6);
	endtask
	task automatic rd(input logic [3:0] a, output logic [23:0] d);
		u_asp_host.xfer({4'h8, a}, 24'h00_0000, 0, d);
	endtask
	// bounded wait for the core handshake; ok low means refused
	task automatic push(input logic [23:0] d, output logic ok);
		int n;
		n = 0;
		cyc(1);
		result_data_i = d;
		result_valid_i = 1'b1;
		// ready is looked at off the edge, where it has settled
		while (result_ready_o !== 1'b1 && n < 20) begin
			n++;
			cyc(1);
		end
		ok = (result_ready_o === 1'b1);
		if (ok) begin
			cyc(1);
		end
		result_valid_i = 1'b0;
		cyc(1);
	endtask
	task automatic t_reset;
		chk("oe deselected", 24'h00_0000, 24'(sdo_oe_o));
		chk("aux idle", 24'h00_0001, 24'(aux));
		chk("stream clock", 24'h00_0000, 24'(sclk_s));
		chk("core released", 24'h00_0000, 24'(core_reset_o));
	endtask
	task automatic t_regs;
		logic [23:0] d;
		rd(`ASP_ADDR_CHAN_EN, d);
		chk("chan_en reset", 24'h00_0001, d);
		wr(`ASP_ADDR_CTRL, 24'h00_0004);
		u_asp_host.xfer({4'h8, `ASP_ADDR_CTRL}, 24'h00_0000, 400, d);
		chk("ctrl burst read", 24'h00_0004, d);
		wr(4'hF, 24'h00_0007);
		rd(4'hF, d);
		chk("unmapped", 24'h00_0000, d);
	endtask
	task automatic t_fill;
		logic [23:0] d;
		logic ok;
		int k;
		k = 0;
		ok = 1'b1;
		while (ok && k < 40) begin
			push(24'h00_0100 + 24'(k), ok);
			if (ok) k++;
			if (ok && k == 1) begin
				chk("aux ready", 24'h00_0000, 24'(aux));
			end
		end
		chk("accepted", 24'h00_0021, 24'(k));
		// last word waits in the stage behind a full fifo, so ready stays high
		chk("aux staged", 24'h00_0001, 24'(aux));
		for (int i = 0; i < 33; i++) begin
			rd(`ASP_ADDR_DATA, d);
			chk("fifo word", 24'h00_0100 + 24'(i), d);
		end
		cyc(4);
		chk("aux drained", 24'h00_0001, 24'(aux));
	endtask
	task automatic t_sync;
		logic [23:0] d;
		logic ok;
		wr(`ASP_ADDR_CHAN_EN, 24'h00_0003);
		push(24'h00_0AAA, ok);
		cyc(2);
		chk("chan advance", 24'h00_0001, 24'(channel_o));
		sync_b_i = 1'b0;
		cyc(5);
		chk("core held", 24'h00_0001, 24'(core_reset_o));
		chk("ready cleared", 24'h00_0001, 24'(aux));
		sync_b_i = 1'b1;
		cyc(5);
		chk("first chan", 24'h00_0000, 24'(channel_o));
		chk("running", 24'h00_0001, 24'(sample_enable_o));
		rd(`ASP_ADDR_DATA, d);
		chk("synced word", 24'h00_0AAA, d);
	endtask
	task automatic t_alt;
		logic [23:0] d;
		logic ok;
		wr(`ASP_ADDR_CTRL, 24'h00_0005);
		push(24'h00_0BBB, ok);
		cyc(3);
		chk("alt chan", 24'h00_0001, 24'(channel_o));
		chk("alt wait", 24'h00_0000, 24'(sample_enable_o));
		sync_b_i = 1'b0;
		cyc(5);
		chk("alt kept low", 24'h00_0001, 24'(channel_o));
		sync_b_i = 1'b1;
		cyc(5);
		chk("alt kept", 24'h00_0001, 24'(channel_o));
		chk("alt sampling", 24'h00_0001, 24'(sample_enable_o));
		rd(`ASP_ADDR_DATA, d);
		chk("alt word", 24'h00_0BBB, d);
	endtask
	task automatic t_stream;
		logic [23:0] w0, w1;
		logic ok;
		wr(`ASP_ADDR_CTRL, 24'h00_0002);
		fork
			begin
				u_asp_host.recv(w0);
				u_asp_host.recv(w1);
			end
			begin
				push(24'h00_A5C3, ok);
				push(24'h00_3C5A, ok);
			end
		join
		chk("stream word0", 24'h00_A5C3, w0);
		chk("stream word1", 24'h00_3C5A, w1);
		chk("stream owns sdo", 24'h00_0001, 24'(sdo_oe_o));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// whole run needs about 155 us; over five times that means a hang
	initial begin
		#800_000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		rst_b_i = 1'b0;
		sync_b_i = 1'b1;
		result_valid_i = 1'b0;
		result_data_i = 24'h00_0000;
		repeat (10) @(posedge clk_i);
		#2 rst_b_i = 1'b1;
		cyc(2);
		t_reset;
		t_regs;
		t_fill;
		t_sync;
		t_alt;
		t_stream;
		tally_and_finish;
	end
endmodule // test_adc_serial_port_and_sync
`default_nettype wire
